// ---- core/sts_map.svh ----
/*
  Constants of the set-point and trip sequencer: clock rate, step timing,
  reserved step-period codes, memory size and reset values.
  Assumes it is included by its bare name from the package and design files.
*/
`ifndef STS_MAP_SVH
`define STS_MAP_SVH

// ----------------------------------------------------------------------------
// Widths
// ----------------------------------------------------------------------------
`define STS_LEVEL_W 16
`define STS_PERIOD_W 20
`define STS_LOC_W 7

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define STS_CLK_PERIOD_PS 5000
`define STS_TICK_MS 10
`define STS_TICK_CYCLES ((`STS_TICK_MS * 1000000) / (`STS_CLK_PERIOD_PS / 1000))

// ----------------------------------------------------------------------------
// Step period codes, in units of one 10 ms tick
// ----------------------------------------------------------------------------
`define STS_PER_STOP 20'h0_0000
`define STS_PER_MAX 20'hF_4114
`define STS_PER_WRAP 20'hF_4178
`define STS_PER_HOLD 20'hF_41DC

// ----------------------------------------------------------------------------
// Memory and reset values
// ----------------------------------------------------------------------------
`define STS_LAST_LOC 7'h63
`define STS_LOC_DEPTH 100
`define STS_LEVEL_RST 16'h0000
`define STS_TRIP_RST 16'hFFFF
`define STS_LIMIT_MAX_RST 16'hFFFF
`define STS_LIMIT_MIN_RST 16'h0000

`endif

// ---- core/sts_pkg.sv ----
/*
  Types of the set-point and trip sequencer: command and query codes and the
  packed structs that carry commands, measurements and memory steps.
  Assumes sts_map.svh is on the include path.
*/
`include "sts_map.svh"

package sts_pkg;

  // --------------------------------------------------------------------------
  // Command codes issued by the command interpreter in front of this block.
  // --------------------------------------------------------------------------
  typedef enum logic [4:0] {
    STS_CMD_SET_VOLT, STS_CMD_SET_VOLT_PEND, STS_CMD_SET_CURR, STS_CMD_SET_CURR_PEND,
    STS_CMD_SET_VTRIP, STS_CMD_SET_CTRIP, STS_CMD_SET_PERIOD, STS_CMD_SET_LOC,
    STS_CMD_STORE, STS_CMD_SET_ARM, STS_CMD_START, STS_CMD_STOP, STS_CMD_PROT_CLEAR,
    STS_CMD_INITIATE, STS_CMD_ABORT, STS_CMD_SET_VMAX, STS_CMD_SET_VMIN,
    STS_CMD_SET_CMAX, STS_CMD_SET_CMIN
  } sts_cmd_code_type;

  // --------------------------------------------------------------------------
  // Readback selectors.
  // --------------------------------------------------------------------------
  typedef enum logic [3:0] {
    STS_Q_VOLT, STS_Q_VOLT_PEND, STS_Q_VOLT_MAX, STS_Q_VOLT_MIN,
    STS_Q_VPEND_MAX, STS_Q_VPEND_MIN, STS_Q_CURR, STS_Q_CURR_PEND,
    STS_Q_CURR_MAX, STS_Q_CURR_MIN, STS_Q_CPEND_MAX, STS_Q_CPEND_MIN,
    STS_Q_VTRIP, STS_Q_CTRIP, STS_Q_PERIOD
  } sts_query_sel_type;

  // One command: valid for one cycle, code and value.
  typedef struct packed {
    logic valid;
    sts_cmd_code_type code;
    logic [`STS_PERIOD_W-1:0] data;
  } sts_cmd_type;

  // One readback request: valid for one cycle.
  typedef struct packed {
    logic valid;
    sts_query_sel_type sel;
  } sts_query_type;

  // Measured output, same clock domain.
  typedef struct packed {
    logic [`STS_LEVEL_W-1:0] voltage;
    logic [`STS_LEVEL_W-1:0] current;
  } sts_meas_type;

  // One auto-sequence memory location.
  typedef struct packed {
    logic [`STS_LEVEL_W-1:0] voltage;
    logic [`STS_LEVEL_W-1:0] current;
    logic [`STS_LEVEL_W-1:0] vtrip;
    logic [`STS_LEVEL_W-1:0] ctrip;
    logic [`STS_PERIOD_W-1:0] period;
  } sts_step_type;

endpackage

// ---- core/sts_step_mem.sv ----
/*
  Step memory of the sequencer: one write port and one read port whose data
  come out of a register one cycle after the address.
  Assumes a single clock; contents are undefined until written.
*/
`timescale 1ns/1ps
`default_nettype none
`include "sts_map.svh"

module sts_step_mem
  import sts_pkg::*;
#(
  parameter int unsigned DEPTH = `STS_LOC_DEPTH
) (
  // Clock
  input wire logic clock_in,
  // Write port
  input wire logic wr_en_in,
  input wire logic [`STS_LOC_W-1:0] wr_addr_in,
  input wire sts_step_type wr_data_in,
  // Read port
  input wire logic [`STS_LOC_W-1:0] rd_addr_in,
  output sts_step_type rd_data_out
);

  // Storage array; no reset so it maps onto block memory.
  sts_step_type mem_q [DEPTH];

  // Write on enable; addresses beyond the depth are dropped.
  always_ff @(posedge clock_in) begin
    if (wr_en_in && (32'(wr_addr_in) < DEPTH)) begin
      mem_q[wr_addr_in] <= wr_data_in;
    end
  end

  // Registered read, one cycle of latency.
  always_ff @(posedge clock_in) begin
    rd_data_out <= mem_q[rd_addr_in];
  end

endmodule

`default_nettype wire

// ---- core/sts_sequencer.sv ----
/*
  Set-point and trip sequencer of a programmable DC supply: immediate and
  pending voltage/current levels, over-voltage and over-current trips, and the
  auto-sequence stepper over the step memory.
  Assumes commands arrive already parsed, one per cycle, and that measured
  values are in the same clock domain and in the same units as the levels.
*/
// Notes on behaviour
// (RULE1) Immediate voltage write drives target at once.
// (RULE2) Trigger copies pending voltage into active set point.
// (RULE3) Pending voltage survives immediate writes until trigger/abort.
// (RULE4) Pending voltage write accepted only when initiated.
// (RULE5) Voltage readback; pending falls back to immediate.
// (RULE6) Max/min voltage readbacks return programmable limits.
// (RULE7) Over-voltage disables output, sets over-voltage flag.
// (RULE8) Voltage trip cleared only by protection clear.
// (RULE9) Immediate current drives output; pending copied on trigger.
// (RULE10) Pending current survives immediate writes until trigger/abort.
// (RULE11) Pending current write accepted only when initiated.
// (RULE12) Current readback with fallback and limit answers.
// (RULE13) Over-current disables output, sets over-current flag.
// (RULE14) Current trip cleared only by protection clear.
// (RULE15) Step period from 10 ms to 9997 s.
// (RULE16) Period code zero stops like stop command.
// (RULE17) Period code 9998 makes location zero next.
// (RULE18) Period code 9999 holds until stop.
// (RULE19) Start advances step early; stop halts output.
// (RULE20) Period readback gives selected location's period.
// (RULE21) Sequence applies each location's settings in order.
// (RULE22) Past location 99, wrap to zero.
// (RULE23) Steps timed by 10 ms prescaled ticks.
`timescale 1ns/1ps
`default_nettype none
`include "sts_map.svh"

module sts_sequencer
  import sts_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = `STS_TICK_CYCLES
) (
  // Clock and reset
  input wire logic clock_in,
  input wire logic srst_in,
  // Commands, readback requests and trigger
  input wire sts_cmd_type cmd_in,
  input wire sts_query_type query_in,
  input wire logic trigger_in,
  // Measured output
  input wire sts_meas_type meas_in,
  // Output drive
  output logic [`STS_LEVEL_W-1:0] voltage_target_out,
  output logic [`STS_LEVEL_W-1:0] current_target_out,
  output logic output_enable_out,
  // Questionable condition bits
  output logic over_voltage_flag_out,
  output logic over_current_flag_out,
  // Readback answer
  output logic query_valid_out,
  output logic [`STS_PERIOD_W-1:0] query_data_out,
  // Status
  output logic cmd_refused_out,
  output logic initiated_out,
  output logic armed_out,
  output logic seq_running_out,
  output logic [`STS_LOC_W-1:0] step_location_out
);

  // --------------------------------------------------------------------------
  // Declarations
  // --------------------------------------------------------------------------
  typedef enum logic [1:0] {ST_IDLE, ST_LOAD, ST_APPLY, ST_RUN} sts_state_type;

  sts_state_type state_q;                        // Sequencer state.
  logic [`STS_LEVEL_W-1:0] volt_q, curr_q;       // Active set points.
  logic [`STS_LEVEL_W-1:0] vpend_q, cpend_q;     // Pending triggered levels.
  logic vpend_held_q, cpend_held_q;              // A pending level is stored.
  logic [`STS_LEVEL_W-1:0] vtrip_q, ctrip_q;     // Trip thresholds.
  logic [`STS_LEVEL_W-1:0] vmax_q, vmin_q;       // Voltage limits.
  logic [`STS_LEVEL_W-1:0] cmax_q, cmin_q;       // Current limits.
  logic [`STS_PERIOD_W-1:0] period_q;            // Period staged for a store.
  logic initiated_q;                             // Trigger subsystem initiated.
  logic arm_q;                                   // Auto-sequence selected.
  logic output_on_q;                             // Output energised.
  logic ov_flag_q, oc_flag_q;                    // Latched trip flags.
  logic hold_q;                                  // Current step never times out.
  logic [`STS_LOC_W-1:0] loc_q;                  // Selected memory location.
  logic [31:0] presc_q;                          // Cycle count inside a tick.
  logic [`STS_PERIOD_W-1:0] ticks_q;             // Ticks spent in the step.
  logic refused_q;
  logic query_valid_q;
  logic [`STS_PERIOD_W-1:0] query_data_q;
  sts_step_type step_rd;                         // Memory data at loc_q.
  sts_step_type step_wr;                         // Data for a store.

  // Command decode helpers.
  logic is_cmd, do_start, do_stop, do_clear, trip_v, trip_i, fault, apply_step, tick;
  logic period_ok;
  logic [`STS_LOC_W-1:0] loc_next;
  logic [`STS_LEVEL_W-1:0] cmd_level;

  // --------------------------------------------------------------------------
  // Combinational decode
  // --------------------------------------------------------------------------
  always_comb begin
    is_cmd = cmd_in.valid;
    cmd_level = cmd_in.data[`STS_LEVEL_W-1:0];
    do_start = is_cmd && (cmd_in.code == STS_CMD_START);
    do_stop = is_cmd && (cmd_in.code == STS_CMD_STOP);
    do_clear = is_cmd && (cmd_in.code == STS_CMD_PROT_CLEAR);
    // A trip is only meaningful while the output is energised.
    trip_v = output_on_q && (meas_in.voltage > vtrip_q); // RULE7
    trip_i = output_on_q && (meas_in.current > ctrip_q); // RULE13
    fault = ov_flag_q || oc_flag_q;
    apply_step = (state_q == ST_APPLY);
    tick = (state_q == ST_RUN) && (presc_q == TICK_CYCLES - 1); // RULE23
    // Ordinary periods run 10 ms .. 9997 s; the three reserved codes also pass.
    period_ok = ((cmd_in.data != `STS_PER_STOP) && (cmd_in.data <= `STS_PER_MAX)) // RULE15
      || (cmd_in.data == `STS_PER_STOP) || (cmd_in.data == `STS_PER_WRAP)
      || (cmd_in.data == `STS_PER_HOLD);
    // The step after the last location is location zero.
    loc_next = (loc_q == `STS_LAST_LOC) ? `STS_LOC_W'(0) : loc_q + `STS_LOC_W'(1); // RULE22
    step_wr = '{voltage: volt_q, current: curr_q, vtrip: vtrip_q, ctrip: ctrip_q, period: period_q};
  end

  // --------------------------------------------------------------------------
  // Step memory; its read address follows the selected location.
  // --------------------------------------------------------------------------
  sts_step_mem #(
    .DEPTH(`STS_LOC_DEPTH)
  ) u_mem (
    .clock_in(clock_in),
    .wr_en_in(is_cmd && (cmd_in.code == STS_CMD_STORE) && (state_q == ST_IDLE)),
    .wr_addr_in(loc_q),
    .wr_data_in(step_wr),
    .rd_addr_in(loc_q),
    .rd_data_out(step_rd)
  );

  // --------------------------------------------------------------------------
  // Active set points: immediate writes, trigger transfer, sequence apply.
  // --------------------------------------------------------------------------
  // A step applied by the sequencer takes priority over a host write in the
  // same cycle, so each location is applied whole.
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      volt_q <= `STS_LEVEL_RST;
      curr_q <= `STS_LEVEL_RST;
    end else if (apply_step) begin
      volt_q <= step_rd.voltage; // RULE21
      curr_q <= step_rd.current;
    end else begin
      if (trigger_in && initiated_q && vpend_held_q) begin
        volt_q <= vpend_q; // RULE2
      end else if (is_cmd && (cmd_in.code == STS_CMD_SET_VOLT)) begin
        volt_q <= cmd_level; // RULE1
      end
      if (trigger_in && initiated_q && cpend_held_q) begin
        curr_q <= cpend_q; // RULE9
      end else if (is_cmd && (cmd_in.code == STS_CMD_SET_CURR)) begin
        curr_q <= cmd_level; // RULE9
      end
    end
  end

  // --------------------------------------------------------------------------
  // Trigger subsystem and pending levels.
  // --------------------------------------------------------------------------
  // Immediate writes never touch the pending registers; only a trigger or an
  // abort retires them.
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      initiated_q <= 1'b0;
      vpend_q <= `STS_LEVEL_RST;
      cpend_q <= `STS_LEVEL_RST;
      vpend_held_q <= 1'b0;
      cpend_held_q <= 1'b0;
    end else if (is_cmd && (cmd_in.code == STS_CMD_ABORT)) begin
      initiated_q <= 1'b0; // RULE3
      vpend_held_q <= 1'b0; // RULE10
      cpend_held_q <= 1'b0;
    end else if (trigger_in && initiated_q) begin
      initiated_q <= 1'b0;
      vpend_held_q <= 1'b0; // RULE3
      cpend_held_q <= 1'b0; // RULE10
    end else if (is_cmd) begin
      case (cmd_in.code)
        STS_CMD_INITIATE: begin
          initiated_q <= 1'b1;
        end
        STS_CMD_SET_VOLT_PEND: begin
          if (initiated_q) begin
            vpend_q <= cmd_level; // RULE4
            vpend_held_q <= 1'b1;
          end
        end
        STS_CMD_SET_CURR_PEND: begin
          if (initiated_q) begin
            cpend_q <= cmd_level; // RULE11
            cpend_held_q <= 1'b1;
          end
        end
        default: begin
          initiated_q <= initiated_q;
        end
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // Trip thresholds, limits, staged period and arm selection.
  // --------------------------------------------------------------------------
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      vtrip_q <= `STS_TRIP_RST;
      ctrip_q <= `STS_TRIP_RST;
      vmax_q <= `STS_LIMIT_MAX_RST;
      vmin_q <= `STS_LIMIT_MIN_RST;
      cmax_q <= `STS_LIMIT_MAX_RST;
      cmin_q <= `STS_LIMIT_MIN_RST;
      period_q <= `STS_PER_STOP;
      arm_q <= 1'b0;
    end else if (apply_step) begin
      vtrip_q <= step_rd.vtrip; // RULE21
      ctrip_q <= step_rd.ctrip;
    end else if (is_cmd) begin
      case (cmd_in.code)
        STS_CMD_SET_VTRIP: vtrip_q <= cmd_level;
        STS_CMD_SET_CTRIP: ctrip_q <= cmd_level;
        STS_CMD_SET_VMAX: vmax_q <= cmd_level;
        STS_CMD_SET_VMIN: vmin_q <= cmd_level;
        STS_CMD_SET_CMAX: cmax_q <= cmd_level;
        STS_CMD_SET_CMIN: cmin_q <= cmd_level;
        STS_CMD_SET_PERIOD: begin
          if (period_ok) begin
            period_q <= cmd_in.data; // RULE15
          end
        end
        STS_CMD_SET_ARM: begin
          if (state_q == ST_IDLE) begin
            arm_q <= cmd_in.data[0];
          end
        end
        default: begin
          arm_q <= arm_q;
        end
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // Refused commands: pending writes while not initiated, bad periods, and
  // start while a trip is latched.
  // --------------------------------------------------------------------------
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      refused_q <= 1'b0;
    end else begin
      refused_q <= is_cmd && (
        (((cmd_in.code == STS_CMD_SET_VOLT_PEND) || (cmd_in.code == STS_CMD_SET_CURR_PEND))
          && !initiated_q)
        || ((cmd_in.code == STS_CMD_SET_PERIOD) && !period_ok)
        || ((cmd_in.code == STS_CMD_START) && fault));
    end
  end

  // --------------------------------------------------------------------------
  // Trip flags: latched until protection clear; a trip in the clear cycle wins.
  // --------------------------------------------------------------------------
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      ov_flag_q <= 1'b0;
      oc_flag_q <= 1'b0;
    end else begin
      ov_flag_q <= (ov_flag_q && !do_clear) || trip_v; // RULE8
      oc_flag_q <= (oc_flag_q && !do_clear) || trip_i; // RULE14
    end
  end

  // --------------------------------------------------------------------------
  // Sequencer: output state, step location and state machine.
  // --------------------------------------------------------------------------
  // A trip or a stop always wins over any sequence progress in the same cycle.
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      state_q <= ST_IDLE;
      output_on_q <= 1'b0;
      loc_q <= '0;
      hold_q <= 1'b0;
    end else if (trip_v || trip_i) begin
      output_on_q <= 1'b0; // RULE7
      state_q <= ST_IDLE; // RULE13
    end else if (do_stop) begin
      output_on_q <= 1'b0; // RULE19
      state_q <= ST_IDLE;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (is_cmd && (cmd_in.code == STS_CMD_SET_LOC) && (cmd_in.data <= `STS_PERIOD_W'(`STS_LAST_LOC))) begin
            loc_q <= cmd_in.data[`STS_LOC_W-1:0];
          end else if (do_start && !fault) begin
            output_on_q <= 1'b1;
            // Normal mode stays here energised; armed mode walks the memory.
            if (arm_q) begin
              state_q <= ST_LOAD;
            end
          end
        end
        ST_LOAD: begin
          // The memory read of loc_q completes during this cycle.
          state_q <= ST_APPLY;
        end
        ST_APPLY: begin
          hold_q <= 1'b0;
          if (step_rd.period == `STS_PER_STOP) begin
            output_on_q <= 1'b0; // RULE16
            state_q <= ST_IDLE;
          end else if (step_rd.period == `STS_PER_WRAP) begin
            loc_q <= '0; // RULE17
            state_q <= ST_LOAD;
          end else begin
            hold_q <= (step_rd.period == `STS_PER_HOLD); // RULE18
            state_q <= ST_RUN;
          end
        end
        ST_RUN: begin
          if (do_start) begin
            loc_q <= loc_next; // RULE19
            state_q <= ST_LOAD;
          end else if (tick && !hold_q && (ticks_q + `STS_PERIOD_W'(1) >= step_rd.period)) begin
            loc_q <= loc_next; // RULE21
            state_q <= ST_LOAD;
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // Step timer: 10 ms prescaler and tick count, restarted at each step.
  // --------------------------------------------------------------------------
  // Counting whole ticks keeps the step counter at 20 bits instead of the
  // 41 bits a raw cycle count of 9997 s would need.
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      presc_q <= '0;
      ticks_q <= '0;
    end else if (state_q != ST_RUN) begin
      presc_q <= '0;
      ticks_q <= '0;
    end else if (tick) begin
      presc_q <= '0; // RULE23
      ticks_q <= ticks_q + `STS_PERIOD_W'(1);
    end else begin
      presc_q <= presc_q + 32'd1;
    end
  end

  // --------------------------------------------------------------------------
  // Readback answers, one cycle after the request.
  // --------------------------------------------------------------------------
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      query_valid_q <= 1'b0;
      query_data_q <= '0;
    end else begin
      query_valid_q <= query_in.valid;
      if (query_in.valid) begin
        case (query_in.sel)
          STS_Q_VOLT: query_data_q <= `STS_PERIOD_W'(volt_q); // RULE5
          STS_Q_VOLT_PEND: query_data_q <= `STS_PERIOD_W'(vpend_held_q ? vpend_q : volt_q); // RULE5
          STS_Q_VOLT_MAX, STS_Q_VPEND_MAX: query_data_q <= `STS_PERIOD_W'(vmax_q); // RULE6
          STS_Q_VOLT_MIN, STS_Q_VPEND_MIN: query_data_q <= `STS_PERIOD_W'(vmin_q); // RULE6
          STS_Q_CURR: query_data_q <= `STS_PERIOD_W'(curr_q); // RULE12
          STS_Q_CURR_PEND: query_data_q <= `STS_PERIOD_W'(cpend_held_q ? cpend_q : curr_q); // RULE12
          STS_Q_CURR_MAX, STS_Q_CPEND_MAX: query_data_q <= `STS_PERIOD_W'(cmax_q); // RULE12
          STS_Q_CURR_MIN, STS_Q_CPEND_MIN: query_data_q <= `STS_PERIOD_W'(cmin_q); // RULE12
          STS_Q_VTRIP: query_data_q <= `STS_PERIOD_W'(vtrip_q);
          STS_Q_CTRIP: query_data_q <= `STS_PERIOD_W'(ctrip_q);
          STS_Q_PERIOD: query_data_q <= step_rd.period; // RULE20
          default: query_data_q <= '0;
        endcase
      end
    end
  end

  // --------------------------------------------------------------------------
  // Outputs, all straight from flip-flops.
  // --------------------------------------------------------------------------
  always_comb begin
    voltage_target_out = volt_q;
    current_target_out = curr_q;
    output_enable_out = output_on_q;
    over_voltage_flag_out = ov_flag_q;
    over_current_flag_out = oc_flag_q;
    query_valid_out = query_valid_q;
    query_data_out = query_data_q;
    cmd_refused_out = refused_q;
    initiated_out = initiated_q;
    armed_out = arm_q;
    step_location_out = loc_q;
  end

  // Running flag registered from the state.
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      seq_running_out <= 1'b0;
    end else begin
      seq_running_out <= (state_q != ST_IDLE) || (arm_q && do_start && !fault && !trip_v && !trip_i && !do_stop);
    end
  end

endmodule

`default_nettype wire

// ---- verif/sts_checker_props.sv ----
/* Port checker of the sequencer, bound at the foot; assumes one clock and a synchronous high reset. */
`timescale 1ns/1ps
`default_nettype none
module sts_checker import sts_pkg::*; (
  // Watched ports
  input wire logic clock_in, srst_in, output_enable_out, over_voltage_flag_out, over_current_flag_out,
  input wire logic cmd_refused_out, initiated_out, armed_out, seq_running_out,
  input wire sts_cmd_type cmd_in,
  input wire logic [15:0] voltage_target_out,
  input wire logic [6:0] step_location_out
);
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (srst_in);
  // Code of the command taken this cycle, or an unused code when none is.
  wire logic [4:0] op = cmd_in.valid ? cmd_in.code : 5'h1F;
  chk_imm_volt: assert property (op == STS_CMD_SET_VOLT && !armed_out && !initiated_out
    |=> voltage_target_out == $past(cmd_in.data[15:0])) else $error("level not applied");
  chk_pend_refused: assert property (!initiated_out
    && op inside {STS_CMD_SET_VOLT_PEND, STS_CMD_SET_CURR_PEND} |=> cmd_refused_out) else $error("not refused");
  chk_ov_off: assert property ($rose(over_voltage_flag_out) |-> !output_enable_out)
    else $error("output on after ov");
  chk_oc_off: assert property ($rose(over_current_flag_out) |-> !output_enable_out)
    else $error("output on after oc");
  chk_ov_latch: assert property (over_voltage_flag_out && op != STS_CMD_PROT_CLEAR
    |=> over_voltage_flag_out) else $error("ov dropped");
  chk_oc_latch: assert property (over_current_flag_out && op != STS_CMD_PROT_CLEAR
    |=> over_current_flag_out) else $error("oc dropped");
  chk_stop_off: assert property (op == STS_CMD_STOP |=> !output_enable_out)
    else $error("stop left output on");
  chk_loc_wrap: assert property (seq_running_out && $past(step_location_out) == 7'h63
    && step_location_out != 7'h63 |-> step_location_out == 7'h00) else $error("no wrap");
  cover property ($rose(over_current_flag_out));
  cover property (seq_running_out && step_location_out == 7'h01);
  cover property (initiated_out);
endmodule
bind sts_sequencer sts_checker sts_checker_i (.*);
`default_nettype wire

// ---- verif/sts_host.sv ----
/* Host model sending one command pulse per call; assumes the bench clock. */
`timescale 1ns/1ps
`default_nettype none
module sts_host import sts_pkg::*; (
  // Clock in, commands out
  input wire logic clock_in,
  output var sts_cmd_type cmd_out
);
  initial cmd_out = '0;
  // Released data is inverted so a stale value never passes for a live one.
  task automatic send(input sts_cmd_code_type k, input logic [19:0] d);
    @(posedge clock_in) #1 cmd_out = {1'b1, k, d};
    @(posedge clock_in) #1 cmd_out = {1'b0, k, ~d};
  endtask
endmodule
`default_nettype wire

// ---- verif/tb.sv ----
/* Sequencer bench with host model; assumes the checker binds itself. */
`timescale 1ns/1ps
`default_nettype none
module tb;
  import sts_pkg::*;
  logic clk = 1'b0, rst = 1'b1, trig = 1'b0, qv, en, ovf, ocf, rf;
  logic [15:0] vt, ct;
  logic [19:0] qd;
  logic [6:0] loc;
  sts_cmd_type cmd;
  sts_query_type qry = '0;
  sts_meas_type meas = '0;
  int err_count = 0, tests_run = 0, n;
  initial forever #2.5 clk = ~clk;
  sts_host sts_host_i (.clock_in(clk), .cmd_out(cmd));
  sts_sequencer #(.TICK_CYCLES(4)) sts_sequencer_i (.clock_in(clk), .srst_in(rst), .cmd_in(cmd),
    .query_in(qry), .trigger_in(trig), .meas_in(meas), .voltage_target_out(vt), .current_target_out(ct),
    .output_enable_out(en), .over_voltage_flag_out(ovf), .over_current_flag_out(ocf), .query_valid_out(qv),
    .query_data_out(qd), .cmd_refused_out(rf), .initiated_out(), .armed_out(), .seq_running_out(),
    .step_location_out(loc));
  task automatic s(input sts_cmd_code_type k, input logic [19:0] d = 20'h0_0000);
    sts_host_i.send(k, d);
  endtask
  task automatic c(input logic [19:0] got, exp);
    tests_run++;
    if (got !== exp) err_count++;
    if (got !== exp) $display("mismatch at %0t: got %h want %h", $time, got, exp);
  endtask
  // The answer is compared once it is flagged, within a short bound.
  task automatic q(input sts_query_sel_type k, input logic [19:0] e);
    @(posedge clk) #1 qry = {1'b1, k};
    @(posedge clk) #1 qry = '0;
    for (n = 0; n < 3 && qv !== 1'b1; n++) @(posedge clk) #1;
    c(qd, e);
  endtask
  task automatic report_and_stop;
    $display("mismatches %0d, checks %0d", err_count, tests_run);
    if (err_count == 0 && tests_run > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic t_levels;
    s(STS_CMD_SET_VOLT, 20'h0_0005);
    c(vt, 20'h0_0005);
    q(STS_Q_VOLT_PEND, 20'h0_0005);
    q(STS_Q_VPEND_MAX, 20'h0_FFFF);
    q(STS_Q_CPEND_MAX, 20'h0_FFFF);
    s(STS_CMD_SET_CURR_PEND, 20'h0_0009);
    c(rf, 20'h0_0001);
    s(STS_CMD_SET_PERIOD, 20'hF_4115);
    c(rf, 20'h0_0001);
  endtask
  task automatic t_trigger;
    s(STS_CMD_INITIATE);
    s(STS_CMD_SET_VOLT_PEND, 20'h0_0009);
    s(STS_CMD_SET_CURR_PEND, 20'h0_0007);
    s(STS_CMD_SET_VOLT, 20'h0_0003);
    q(STS_Q_VOLT_PEND, 20'h0_0009);
    @(posedge clk) #1 trig = 1'b1;
    @(posedge clk) #1 trig = 1'b0;
    c(vt, 20'h0_0009);
    c(ct, 20'h0_0007);
    s(STS_CMD_INITIATE);
    s(STS_CMD_SET_CURR_PEND, 20'h0_000B);
    s(STS_CMD_ABORT);
    q(STS_Q_CURR_PEND, 20'h0_0007);
  endtask
  // Each pass trips one quantity, removes the cause, then clears.
  task automatic t_trip;
    s(STS_CMD_SET_VTRIP, 20'h0_0064);
    s(STS_CMD_SET_CTRIP, 20'h0_0032);
    for (int i = 0; i < 2; i++) begin
      s(STS_CMD_START);
      meas = i ? 32'h0000_0033 : 32'h0065_0000;
      repeat (2) @(posedge clk) #1;
      meas = '0;
      c({en, ocf, ovf}, i ? 20'h0_0002 : 20'h0_0001);
      s(STS_CMD_PROT_CLEAR);
      c({ocf, ovf}, 20'h0_0000);
    end
  endtask
  // Location 99 wraps to 0, 0 dwells two ticks, 1 jumps back to 0.
  task automatic t_seq;
    s(STS_CMD_SET_LOC, 20'h0_0001);
    s(STS_CMD_SET_PERIOD, 20'hF_4178);
    s(STS_CMD_SET_VOLT, 20'h0_001E);
    s(STS_CMD_STORE);
    q(STS_Q_PERIOD, 20'hF_4178);
    s(STS_CMD_SET_LOC);
    s(STS_CMD_SET_PERIOD, 20'h0_0002);
    s(STS_CMD_SET_VOLT, 20'h0_0014);
    s(STS_CMD_STORE);
    s(STS_CMD_SET_LOC, 20'h0_0063);
    s(STS_CMD_STORE);
    s(STS_CMD_SET_ARM, 20'h0_0001);
    s(STS_CMD_START);
    for (n = 0; n < 40 && loc === 7'h63; n++) @(posedge clk) #1;
    c(loc, 20'h0_0000);
    for (n = 0; n < 40 && loc !== 7'h01; n++) @(posedge clk) #1;
    c(20'(n), 20'h0_000A);
    for (n = 0; n < 40 && vt !== 16'h001E; n++) @(posedge clk) #1;
    c(loc, 20'h0_0000);
    s(STS_CMD_STOP);
    c(en, 20'h0_0000);
  endtask
  initial begin
    repeat (5) @(posedge clk);
    #1 rst = 1'b0;
    t_levels;
    t_trigger;
    t_trip;
    t_seq;
    report_and_stop;
  end
  // A hang is cut short well beyond the hundred or so cycles the run needs.
  initial begin
    #20000;
    err_count++;
    report_and_stop;
  end
endmodule
`default_nettype wire
